// *** core/fot_pkg.sv ***
// constants for the fail-safe output test monitor
package fot_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S; // cycles per ms
  localparam int unsigned INTERVAL_DEF_H = 8;
  localparam int unsigned INTERVAL_DEF_MS = INTERVAL_DEF_H * 3600 * MS_PER_S;
  localparam int unsigned WAIT_DEF_MS = 500;
  localparam int unsigned MIN_WAIT_MS = 24;
  // ==========================================================
  // widths
  localparam int unsigned IVL_W = 25;
  localparam int unsigned WAIT_W = 16;
  localparam int unsigned SLOTS = 6;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned NSTAT = 8;
  localparam int unsigned NPIN = 4;
  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFS_SRC = 6'h00;
  localparam logic [5:0] OFS_SAFE = 6'h04;
  localparam logic [5:0] OFS_TCFG = 6'h08;
  localparam logic [5:0] OFS_IVL = 6'h0c;
  localparam logic [5:0] OFS_WAIT = 6'h10;
  localparam logic [5:0] OFS_REM = 6'h14;
  localparam logic [5:0] OFS_STAT = 6'h18;
  localparam logic [5:0] OFS_MASK = 6'h1c;
  localparam logic [5:0] OFS_STATE = 6'h20;
  // ==========================================================
  // field positions and reset values
  localparam int unsigned TCFG_MODE_LSB = 0;
  localparam int unsigned TCFG_FB_LSB = 4;
  localparam int unsigned TCFG_TRIG_LSB = 8;
  localparam logic [3:0] MODE_RST = 4'h4; // 0100 bin
  localparam logic [3:0] FB_RST = 4'h0; // 0000 bin
  localparam logic [2:0] TRIG_RST = 3'h0;
  localparam logic [7:0] SAFE_RST = 8'h01; // 0000 0001 bin
  localparam logic [3:0] SLOT_NONE = 4'h0;
  localparam logic [3:0] SLOT_SAFE = 4'h9;
  localparam logic [3:0] MODE_DO2 = 4'h1;
  localparam logic [3:0] MODE_FB = 4'h2;
  localparam logic [3:0] MODE_FBN = 4'h3;
  localparam logic [3:0] MODE_NONE = 4'h4;
  localparam int unsigned ST_REQ = 0;
  localparam int unsigned ST_PASS = 1;
  localparam int unsigned ST_FAIL = 2;
  localparam int unsigned NEV = 3;
  // ==========================================================
  // self-test sequencer states
  typedef enum logic [1:0] {
    FOT_IDLE,
    FOT_STEP_A,
    FOT_STEP_B
  } fot_state_t;
endpackage

// *** core/fot_tick_if.sv ***
// millisecond tick shared between divider and monitor
`timescale 1ns/100ps
`default_nettype none
interface fot_tick_if;
  logic ms_tick;
  modport gen (output ms_tick);
  modport use_tick (input ms_tick);
endinterface
`default_nettype wire

// *** core/fot_tick_gen.sv ***
// divider making a one-cycle millisecond enable
`timescale 1ns/100ps
`default_nettype none
module fot_tick_gen #(
  parameter int unsigned CYC_PER_MS = fot_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // tick out
  fot_tick_if.gen tick
);
  logic [17:0] cnt;
  logic [17:0] next_cnt;
  logic pulse;
  logic next_pulse;

  // ==========================================================
  // divider
  // count down so the compare is against a constant zero
  always_comb begin
    next_pulse = 1'b0;
    next_cnt = cnt - 18'h1;
    if (cnt == 18'h0) begin
      next_cnt = 18'(CYC_PER_MS - 1);
      next_pulse = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt <= 18'h0;
      pulse <= 1'b0;
    end else begin
      cnt <= next_cnt;
      pulse <= next_pulse;
    end
  end

  assign tick.ms_tick = pulse;
endmodule
`default_nettype wire

// *** core/fot_monitor.sv ***
// fail-safe output combiner with periodic shut-down self-test
`timescale 1ns/100ps
`default_nettype none
module fot_monitor #(
  parameter int unsigned CYC_PER_MS = fot_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // avalon-mm slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // internal status sources, same clock
  input wire logic [7:0] status_in,
  // pins from outside
  input wire logic [3:0] trig_pin,
  input wire logic [3:0] fb_pin,
  input wire logic do2_sense,
  // fail-safe output pair and flags
  output logic fsdo_a,
  output logic fsdo_b,
  output logic test_required,
  output logic irq
);
  // ==========================================================
  // pin synchronisers
  logic [8:0] sync1;
  logic [8:0] sync2;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1 <= 9'h0;
      sync2 <= 9'h0;
    end else begin
      sync1 <= {do2_sense, fb_pin, trig_pin};
      sync2 <= sync1;
    end
  end

  fot_tick_if tk ();
  fot_tick_gen #(.CYC_PER_MS(CYC_PER_MS)) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .tick(tk.gen)
  );

  // ==========================================================
  // registers
  logic [23:0] src_sel, next_src_sel;
  logic [7:0] safe_sel, next_safe_sel;
  logic [3:0] mode, next_mode;
  logic [3:0] fb_en, next_fb_en;
  logic [2:0] trig_sel, next_trig_sel;
  logic [24:0] ivl, next_ivl;
  logic [15:0] wait_ms, next_wait_ms;
  logic [2:0] stat, next_stat;
  logic [2:0] mask, next_mask;
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic [2:0] ev; // event pulses from the interval timer and the sequencer
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic wr_go;
  logic [24:0] remain;
  fot_pkg::fot_state_t state;

  // byte lanes into a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
  end

  // one wait cycle per access: read data comes from a flop
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_go = avs_write & ack;
  assign avs_readdata = rdata;

  // readback multiplexer, unmapped reads return zero
  always_comb begin
    case (avs_address)
      fot_pkg::OFS_SRC: rd_mux = {8'h0, src_sel};
      fot_pkg::OFS_SAFE: rd_mux = {24'h0, safe_sel};
      fot_pkg::OFS_TCFG: rd_mux = {21'h0, trig_sel, fb_en, mode};
      fot_pkg::OFS_IVL: rd_mux = {7'h0, ivl};
      fot_pkg::OFS_WAIT: rd_mux = {16'h0, wait_ms};
      fot_pkg::OFS_REM: rd_mux = {7'h0, remain};
      fot_pkg::OFS_STAT: rd_mux = {29'h0, stat};
      fot_pkg::OFS_MASK: rd_mux = {29'h0, mask};
      fot_pkg::OFS_STATE: rd_mux = {27'h0, test_required,
        state != fot_pkg::FOT_IDLE, fsdo_b, fsdo_a, 1'b0};
      default: rd_mux = 32'h0;
    endcase
  end

  // register write decode; set beats clear on the status bits
  always_comb begin
    logic [31:0] m;
    m = avs_writedata & wmask;
    next_ack = (avs_read | avs_write) & ~ack;
    next_rdata = (avs_read & ~ack) ? rd_mux : rdata;
    next_src_sel = src_sel;
    next_safe_sel = safe_sel;
    next_mode = mode;
    next_fb_en = fb_en;
    next_trig_sel = trig_sel;
    next_ivl = ivl;
    next_wait_ms = wait_ms;
    next_mask = mask;
    next_stat = stat;
    if (wr_go) begin
      case (avs_address)
        fot_pkg::OFS_SRC:
          next_src_sel = (src_sel & ~wmask[23:0]) | m[23:0];
        fot_pkg::OFS_SAFE:
          next_safe_sel = (safe_sel & ~wmask[7:0]) | m[7:0];
        fot_pkg::OFS_TCFG: begin
          if (avs_byteenable[0]) begin
            next_mode = avs_writedata[3:0];
            next_fb_en = avs_writedata[7:4];
          end
          if (avs_byteenable[1]) begin
            next_trig_sel = avs_writedata[10:8];
          end
        end
        fot_pkg::OFS_IVL:
          next_ivl = (ivl & ~wmask[24:0]) | m[24:0];
        fot_pkg::OFS_WAIT:
          next_wait_ms = (wait_ms & ~wmask[15:0]) | m[15:0];
        fot_pkg::OFS_STAT: next_stat = stat & ~m[2:0];
        fot_pkg::OFS_MASK:
          next_mask = (mask & ~wmask[2:0]) | m[2:0];
        default: next_ack = next_ack; // unmapped writes are dropped
      endcase
    end
    next_stat = next_stat | ev;
  end

  // register file flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      src_sel <= 24'h0;
      safe_sel <= fot_pkg::SAFE_RST;
      mode <= fot_pkg::MODE_RST;
      fb_en <= fot_pkg::FB_RST;
      trig_sel <= fot_pkg::TRIG_RST;
      ivl <= 25'(fot_pkg::INTERVAL_DEF_MS);
      wait_ms <= 16'(fot_pkg::WAIT_DEF_MS);
      stat <= 3'h0;
      mask <= 3'h0;
      rdata <= 32'h0;
      ack <= 1'b0;
    end else begin
      src_sel <= next_src_sel;
      safe_sel <= next_safe_sel;
      mode <= next_mode;
      fb_en <= next_fb_en;
      trig_sel <= next_trig_sel;
      ivl <= next_ivl;
      wait_ms <= next_wait_ms;
      stat <= next_stat;
      mask <= next_mask;
      rdata <= next_rdata;
      ack <= next_ack;
    end
  end

  assign irq = |(stat & mask);

  // ==========================================================
  // output source combination
  logic safe_state;
  logic [5:0] slot_val;
  logic [5:0] slot_used;
  logic combined;
  assign safe_state = |(status_in & safe_sel);

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_slot
      logic [3:0] s;
      assign s = src_sel[g*4 +: 4];
      assign slot_used[g] = (s != fot_pkg::SLOT_NONE) &&
        (s <= fot_pkg::SLOT_SAFE);
      // unconnected slots are forced to 1 so the and ignores them
      assign slot_val[g] = !slot_used[g] ? 1'b1 :
        (s == fot_pkg::SLOT_SAFE) ? safe_state :
        status_in[3'(s - 4'h1)];
    end
  endgenerate

  // and of connected slots; none connected reads as zero
  assign combined = (|slot_used) & (&slot_val);

  // ==========================================================
  // trigger edge and interval timer
  logic trig_lvl, trig_prev, next_trig_prev, trig_rise;
  logic [24:0] next_remain;
  logic req, next_req;
  logic req_set;
  assign trig_lvl = (trig_sel == 3'h0 || trig_sel > 3'h4) ? 1'b0 :
    sync2[2'(trig_sel - 3'h1)];
  assign trig_rise = trig_lvl & ~trig_prev;

  // countdown in ms; zero is sticky until the next trigger
  always_comb begin
    next_trig_prev = trig_lvl;
    next_remain = remain;
    next_req = req;
    req_set = 1'b0;
    if (trig_rise) begin
      next_remain = ivl;
      next_req = 1'b0;
    end else if (tk.ms_tick && remain != 25'h0) begin
      next_remain = remain - 25'h1;
      if (remain == 25'h1) begin
        next_req = 1'b1;
        req_set = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      trig_prev <= 1'b0;
      remain <= 25'(fot_pkg::INTERVAL_DEF_MS);
      req <= 1'b0;
    end else begin
      trig_prev <= next_trig_prev;
      remain <= next_remain;
      req <= next_req;
    end
  end

  assign test_required = req;

  // ==========================================================
  // self-test sequencer
  fot_pkg::fot_state_t next_state;
  logic [15:0] step_ms, next_step_ms;
  logic [15:0] eff_wait;
  logic out_a, out_b, next_out_a, next_out_b;
  logic fb_lvl, seen, min_done;
  logic pass_ev, fail_ev;
  // short settings are stretched to the floor of 24 ms
  assign eff_wait = (wait_ms < 16'(fot_pkg::MIN_WAIT_MS)) ?
    16'(fot_pkg::MIN_WAIT_MS) : wait_ms;
  assign fb_lvl = |(sync2[7:4] & fb_en);
  assign min_done = step_ms >= 16'(fot_pkg::MIN_WAIT_MS);

  // expected read-back of output b in this step
  always_comb begin
    case (mode)
      fot_pkg::MODE_DO2: seen = sync2[8] == out_b;
      fot_pkg::MODE_FB: seen = fb_lvl == out_b;
      fot_pkg::MODE_FBN: seen = fb_lvl != out_b;
      fot_pkg::MODE_NONE: seen = 1'b1;
      default: seen = 1'b1;
    endcase
  end

  // step a: a off, b on; step b: a on, b off
  always_comb begin
    next_state = state;
    next_step_ms = tk.ms_tick ? step_ms + 16'h1 : step_ms;
    next_out_a = out_a;
    next_out_b = out_b;
    pass_ev = 1'b0;
    fail_ev = 1'b0;
    case (state)
      fot_pkg::FOT_IDLE: begin
        next_out_a = combined;
        next_out_b = combined;
        next_step_ms = 16'h0;
        if (trig_rise) begin
          next_state = fot_pkg::FOT_STEP_A;
          next_out_a = 1'b0;
          next_out_b = 1'b1;
        end
      end
      fot_pkg::FOT_STEP_A, fot_pkg::FOT_STEP_B: begin
        if (min_done && seen) begin
          next_step_ms = 16'h0;
          if (state == fot_pkg::FOT_STEP_A) begin
            next_state = fot_pkg::FOT_STEP_B;
            next_out_a = 1'b1;
            next_out_b = 1'b0;
          end else begin
            next_state = fot_pkg::FOT_IDLE;
            next_out_a = combined;
            next_out_b = combined;
            pass_ev = 1'b1;
          end
        end else if (step_ms >= eff_wait) begin
          next_state = fot_pkg::FOT_IDLE;
          next_out_a = combined;
          next_out_b = combined;
          fail_ev = 1'b1;
        end
      end
      default: next_state = fot_pkg::FOT_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= fot_pkg::FOT_IDLE;
      step_ms <= 16'h0;
      out_a <= 1'b0;
      out_b <= 1'b0;
    end else begin
      state <= next_state;
      step_ms <= next_step_ms;
      out_a <= next_out_a;
      out_b <= next_out_b;
    end
  end

  assign fsdo_a = out_a;
  assign fsdo_b = out_b;
  assign ev = {fail_ev, pass_ev, req_set};
endmodule
`default_nettype wire

// *** core/fot_dummy_unused.sv ***
// reserved file, holds no logic
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// *** sim/fot_actuator.sv ***
// actuator and feedback wiring model on the far side of the output pair
`timescale 1ns/100ps
`default_nettype none
module fot_actuator #(
  parameter int unsigned DLY = 3
) (
  // clock
  input wire logic clk,
  // output b and fault controls
  input wire logic fsdo_b,
  input wire logic stuck,
  input wire logic invert,
  // read-back toward the device
  output logic do2_sense,
  output logic [3:0] fb_pin
);
  logic [DLY-1:0] dly = {DLY{1'b0}};
  logic tog = 1'b0;
  logic seen;
  // actuator response, far shorter than any wait time
  always @(posedge clk) begin
    dly <= {dly[DLY-2:0], fsdo_b};
    tog <= ~tog;
  end
  // a welded contact keeps reporting on
  assign seen = stuck | dly[DLY-1];
  assign do2_sense = seen;
  // unused feedback pins float, so they wander every cycle
  // read-back sits on pin 1, the one the bench enables
  assign fb_pin = {tog, ~tog, seen ^ invert, tog};
endmodule
`default_nettype wire

// *** sim/fot_monitor_asserts.sv ***
// concurrent checks on the fail-safe output test monitor ports
`timescale 1ns/100ps
`default_nettype none
module fot_monitor_asserts #(
  parameter int unsigned CYC_PER_MS = fot_pkg::MS_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // outputs
  input wire logic fsdo_a,
  input wire logic fsdo_b,
  input wire logic test_required,
  input wire logic irq
);
  // first ms of a step may be short, so 23 whole ms is the floor
  localparam int unsigned MINC = 23 * CYC_PER_MS;
  logic [1:0] pair;
  logic [1:0] pair_q;
  logic [1:0] next_pair_q;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  assign pair = {fsdo_a, fsdo_b};
  // cycles the pair has held its present value
  always_comb begin
    next_pair_q = pair;
    next_cnt = (pair != pair_q) ? 32'h1 : cnt + 32'h1;
  end
  // cleared in reset so the hold count is never unknown
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pair_q <= 2'b00;
      cnt <= 32'h0;
    end else begin
      pair_q <= next_pair_q;
      cnt <= next_cnt;
    end
  end
  // ==========================================================
  // register bus
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest;
  endsequence
  property p_req_ans;
    s_taken |=> s_answer;
  endproperty
  a_req_ans: assert property (p_req_ans) else $error("late answer");
  property p_req_wait;
    (avs_read || avs_write) && !$past(avs_read || avs_write)
      |-> avs_waitrequest;
  endproperty
  a_req_wait: assert property (p_req_wait) else $error("no wait cycle");
  property p_rd_hold;
    !(avs_read && avs_waitrequest) |=> $stable(avs_readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_irq_fall;
    $fell(irq) |-> $past(avs_write && !avs_waitrequest);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  property p_rst_quiet;
    disable iff (1'b0)
    !rst_b [*2] |-> !fsdo_a && !fsdo_b && !test_required && !irq;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("reset leak");
  // ==========================================================
  // self-test steps
  property p_step_a_in;
    pair == 2'b01 && $past(pair) != 2'b01 |-> ^$past(pair) == 1'b0;
  endproperty
  a_step_a_in: assert property (p_step_a_in) else $error("bad entry");
  property p_step_b_in;
    pair == 2'b10 && $past(pair) != 2'b10 |-> $past(pair) == 2'b01;
  endproperty
  a_step_b_in: assert property (p_step_b_in) else $error("bad order");
  property p_step_len;
    pair != $past(pair) && ^$past(pair) |-> cnt >= MINC;
  endproperty
  a_step_len: assert property (p_step_len) else $error("short step");
endmodule
bind fot_monitor fot_monitor_asserts #(.CYC_PER_MS(CYC_PER_MS)) u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .fsdo_a(fsdo_a),
  .fsdo_b(fsdo_b),
  .test_required(test_required),
  .irq(irq)
);
`default_nettype wire

// *** sim/fot_monitor_tb.sv ***
// self-checking bench for the fail-safe output test monitor
`timescale 1ns/100ps
`default_nettype none
module fot_monitor_tb;
  // ==========================================================
  // signals
  localparam int unsigned CYC = 10;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] status_in = 8'h00;
  logic [3:0] trig_pin = 4'h0;
  logic [3:0] fb_pin;
  logic do2_sense, fsdo_a, fsdo_b, test_required, irq;
  logic stuck = 1'b0;
  logic invert = 1'b0;
  logic [31:0] rd;
  int err_total = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  fot_monitor #(.CYC_PER_MS(CYC)) uut (
    .clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .status_in(status_in), .trig_pin(trig_pin), .fb_pin(fb_pin),
    .do2_sense(do2_sense), .fsdo_a(fsdo_a), .fsdo_b(fsdo_b),
    .test_required(test_required), .irq(irq)
  );
  fot_actuator u_act (
    .clk(clk), .fsdo_b(fsdo_b), .stuck(stuck), .invert(invert),
    .do2_sense(do2_sense), .fb_pin(fb_pin)
  );
  // ==========================================================
  // shared tasks
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 20) begin
      err_total++;
      final_report();
    end
  endtask
  // cycles spent while the output pair holds p
  task automatic span(input logic [1:0] p, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ({fsdo_a, fsdo_b} === p && n < 2000);
    if (n >= 2000) begin
      err_total++;
      final_report();
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    bus(1'b0, fot_pkg::OFS_TCFG, 32'h0);
    cmp(rd, 32'h4);
    bus(1'b0, fot_pkg::OFS_SAFE, 32'h0);
    cmp(rd, 32'h1);
    bus(1'b0, 6'h3c, 32'h0);
    cmp(rd, 32'h0);
  endtask
  task automatic t_combine();
    int s;
    logic e;
    status_in <= 8'hff;
    repeat (3) @(posedge clk);
    cmp({30'h0, fsdo_a, fsdo_b}, 32'h0);
    // slot 0 on status bit 1, slot 1 unconnected, slot 5 on safe state
    bus(1'b1, fot_pkg::OFS_SRC, 32'h9000a2);
    for (s = 0; s < 8; s++) begin
      status_in <= {6'h0, s[1:0]};
      bus(1'b1, fot_pkg::OFS_SAFE, s[2] ? 32'h2 : 32'h1);
      repeat (3) @(posedge clk);
      e = s[1] & s[s[2]];
      cmp({30'h0, fsdo_a, fsdo_b}, {30'h0, e, e});
    end
    bus(1'b1, fot_pkg::OFS_SRC, 32'h0);
  endtask
  task automatic t_test(input logic [3:0] mode, input logic [3:0] fb,
                        input logic stk, input logic inv, input logic ok);
    int la;
    int lb;
    stuck <= stk;
    invert <= inv;
    bus(1'b1, fot_pkg::OFS_TCFG, {20'h0, 4'h1, fb, mode});
    // one trigger line serves every self-test
    trig_pin <= 4'h1;
    span(2'b00, la);
    span(2'b01, la);
    span(2'b10, lb);
    cmp({31'h0, la >= 23 * CYC && la <= 32 * CYC}, 32'h1);
    cmp({31'h0, lb >= (ok ? 23 : 29) * CYC && lb <= 32 * CYC}, 32'h1);
    bus(1'b0, fot_pkg::OFS_STAT, 32'h0);
    cmp(rd, ok ? 32'h2 : 32'h4);
    bus(1'b1, fot_pkg::OFS_STAT, 32'h7);
    trig_pin <= 4'h0;
  endtask
  task automatic t_required();
    // no safety test interval here, so any interval is long enough
    bus(1'b1, fot_pkg::OFS_IVL, 32'h3);
    bus(1'b1, fot_pkg::OFS_MASK, 32'h1);
    trig_pin <= 4'h1;
    repeat (500) @(posedge clk);
    cmp({30'h0, test_required, irq}, 32'h3);
    bus(1'b1, fot_pkg::OFS_MASK, 32'h0);
    @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    bus(1'b1, fot_pkg::OFS_MASK, 32'h1);
    bus(1'b1, fot_pkg::OFS_STAT, 32'h7);
    @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    trig_pin <= 4'h0;
    repeat (4) @(posedge clk);
    trig_pin <= 4'h1;
    repeat (6) @(posedge clk);
    cmp({31'h0, test_required}, 32'h0);
    bus(1'b0, fot_pkg::OFS_REM, 32'h0);
    cmp({31'h0, rd == 32'h3 || rd == 32'h2}, 32'h1);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_combine();
    bus(1'b1, fot_pkg::OFS_WAIT, 32'h1e);
    t_test(4'h1, 4'h0, 1'b0, 1'b0, 1'b1);
    t_test(4'h2, 4'h2, 1'b0, 1'b0, 1'b1);
    t_test(4'h3, 4'h2, 1'b0, 1'b1, 1'b1);
    t_test(4'h4, 4'h0, 1'b1, 1'b0, 1'b1);
    t_test(4'h1, 4'h0, 1'b1, 1'b0, 1'b0);
    t_required();
    final_report();
  end
endmodule
`default_nettype wire
